// [design/motor_command_frame_parser.sv]
// Command frame receiver, executor and reply sender with AHB-Lite registers
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module motor_command_frame_parser #(
    parameter int RX_TIMEOUT = frame_pkg::RX_TIMEOUT_CYC
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic [31:0]                hrdata,
    output logic                       hresp,
    input  wire logic                  rx_valid,
    input  wire logic [7:0]            rx_data,
    output logic                       tx_valid,
    output logic [7:0]                 tx_data,
    input  wire logic                  tx_ready,
    input  wire logic [3:0]            status_pins,
    output frame_pkg::motion_cfg_t     motion_cfg,
    output frame_pkg::run_cmd_t        run_cmd
);
    import frame_pkg::*;

    // Closed range test on a data field
    function automatic logic in_range(input logic [31:0] val, input logic [31:0] lo,
                                      input logic [31:0] hi);
        return (val >= lo) && (val <= hi);
    endfunction

    typedef enum logic [1:0] {
        ST_COLLECT = 2'b00,
        ST_EXEC    = 2'b01,
        ST_REPLY   = 2'b10
    } state_t;

    state_t      state;
    logic [7:0]  rx_buf [0:7];
    logic [7:0]  tx_buf [0:7];
    logic [3:0]  rx_cnt;
    logic [3:0]  tx_cnt;
    logic [7:0]  rx_sum;
    logic [31:0] idle_cnt;
    logic [3:0]  stat_meta;
    logic [3:0]  stat_sync;
    logic [7:0]  dev_addr;
    logic [15:0] frames_ok;
    logic [15:0] frames_dropped;
    logic        ahb_wr;
    logic [7:0]  ahb_addr;

    // Pin inputs pass two flip-flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_meta <= 4'h0;
            stat_sync <= 4'h0;
        end else begin
            stat_meta <= status_pins;
            stat_sync <= stat_meta;
        end
    end

    // Frame fields
    wire [7:0]  f_addr   = rx_buf[1];
    wire [7:0]  f_op     = rx_buf[2];
    wire [31:0] f_arg    = {rx_buf[6], rx_buf[5], rx_buf[4], rx_buf[3]}; // [RULE14]
    wire        busy     = stat_sync[STAT_BUSY];
    wire        home     = stat_sync[STAT_HOME];
    wire        addr_ok  = (dev_addr == FACTORY_ADDR) ||
                           (dev_addr >= ADDR_MIN && dev_addr <= ADDR_MAX); // [RULE10]
    wire        match    = addr_ok && (f_addr == dev_addr); // [RULE3]
    wire        sum_ok   = (rx_sum == rx_buf[7]); // [RULE15] [RULE16]
    wire        rx_take  = rx_valid && (state == ST_COLLECT);
    wire        lead_ok  = (rx_cnt != 4'h0) || (rx_data == LEAD_BYTE); // [RULE2]
    wire        timed_out = (rx_cnt != 4'h0) && (idle_cnt >= 32'(RX_TIMEOUT - 1));
    wire        tx_fire  = tx_valid && tx_ready;
    wire        rx_last  = (rx_cnt == FRAME_LEN - 4'h1);
    wire        tx_last  = (tx_cnt == FRAME_LEN - 4'h1);
    wire        cur_in   = in_range(f_arg, CUR_MIN, CUR_MAX); // [RULE17]
    wire        hspd_in  = in_range(f_arg, HSPD_MIN, HSPD_MAX); // [RULE18]
    wire        arg_zero = (f_arg == 32'h0); // [RULE6]
    wire        arg_bit  = (f_arg[31:1] == 31'h0);

    // Instruction decode
    // Replies to set codes carry the value held before the write
    logic [31:0] reply_data;
    logic        set_cur;
    logic        set_hspd;
    logic        set_mode;
    logic        set_dir;
    logic        do_step;
    logic        do_test;

    always_comb begin
        reply_data = 32'h0;
        set_cur    = 1'b0;
        set_hspd   = 1'b0;
        set_mode   = 1'b0;
        set_dir    = 1'b0;
        do_step    = 1'b0;
        do_test    = 1'b0;
        case (f_op)
            OP_CURRENT: begin
                reply_data = motion_cfg.current_ma; // [RULE6]
                if (!arg_zero) begin
                    if (cur_in) begin
                        set_cur = 1'b1; // [RULE17]
                    end else begin
                        reply_data = ERR_STATE; // [RULE7] [RULE9]
                    end
                end
            end

            OP_HOME_SPEED: begin
                reply_data = motion_cfg.home_speed; // [RULE6]
                if (!arg_zero) begin
                    if (hspd_in) begin
                        set_hspd = 1'b1; // [RULE18]
                    end else begin
                        reply_data = ERR_STATE; // [RULE7] [RULE9]
                    end
                end
            end

            OP_SPEED_MODE: begin
                reply_data = {31'h0, motion_cfg.speed_mode};
                if (arg_bit) begin
                    set_mode = 1'b1; // [RULE19]
                end else begin
                    reply_data = ERR_STATE; // [RULE7] [RULE9]
                end
            end

            OP_DIRECTION: begin
                reply_data = {31'h0, motion_cfg.direction};
                if (arg_bit) begin
                    set_dir = 1'b1; // [RULE20]
                end else begin
                    reply_data = ERR_STATE; // [RULE7] [RULE9]
                end
            end

            OP_STATUS1: begin
                reply_data = {28'h0, stat_sync}; // [RULE5] [RULE21] [RULE13]
            end

            OP_TEST_RUN: begin
                if (busy) begin
                    reply_data = ERR_STATE; // [RULE7]
                end else begin
                    do_test = 1'b1; // [RULE22] [RULE13]
                end
            end

            OP_STEP: begin
                reply_data = f_arg;
                if (busy) begin
                    reply_data = ERR_STATE; // [RULE4] [RULE7]
                end else if (home && motion_cfg.direction) begin
                    reply_data = ERR_UNKNOWN; // [RULE8]
                end else begin
                    do_step = 1'b1;
                end
            end

            default: begin
                reply_data = ERR_UNKNOWN; // [RULE8]
            end
        endcase
    end

    // Reply assembly
    wire [7:0] reply_sum = 8'(LEAD_BYTE + REPLY_MARK + dev_addr + reply_data[7:0] +
                              reply_data[15:8] + reply_data[23:16] +
                              reply_data[31:24]); // [RULE15]

    // Receive, execute and reply sequence
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state          <= ST_COLLECT;
            rx_cnt         <= 4'h0;
            tx_cnt         <= 4'h0;
            rx_sum         <= 8'h0;
            idle_cnt       <= 32'h0;
            tx_valid       <= 1'b0;
            tx_data        <= 8'h0;
            frames_ok      <= 16'h0;
            frames_dropped <= 16'h0;
            for (int i = 0; i < 8; i++) begin
                rx_buf[i] <= 8'h0;
                tx_buf[i] <= 8'h0;
            end
        end else begin
            case (state)
                ST_COLLECT: begin
                    if (rx_take && lead_ok) begin
                        rx_buf[rx_cnt[2:0]] <= rx_data; // [RULE1]
                        idle_cnt <= 32'h0;
                        if (rx_cnt != 4'h7) begin
                            rx_sum <= 8'(rx_sum + rx_data);
                        end
                        if (rx_last) begin
                            rx_cnt <= 4'h0;
                            state  <= ST_EXEC; // [RULE24]
                        end else begin
                            rx_cnt <= 4'(rx_cnt + 4'h1);
                        end
                    end else if (timed_out) begin
                        rx_cnt         <= 4'h0; // [RULE23]
                        rx_sum         <= 8'h0;
                        idle_cnt       <= 32'h0;
                        frames_dropped <= 16'(frames_dropped + 16'h1);
                    end else if (rx_cnt != 4'h0) begin
                        idle_cnt <= 32'(idle_cnt + 32'h1);
                    end
                end
                ST_EXEC: begin
                    rx_sum <= 8'h0;
                    if (match && sum_ok) begin
                        tx_buf[0] <= LEAD_BYTE;
                        tx_buf[1] <= REPLY_MARK; // [RULE11]
                        tx_buf[2] <= dev_addr; // [RULE12]
                        tx_buf[3] <= reply_data[7:0]; // [RULE14]
                        tx_buf[4] <= reply_data[15:8];
                        tx_buf[5] <= reply_data[23:16];
                        tx_buf[6] <= reply_data[31:24];
                        tx_buf[7] <= reply_sum;
                        tx_data   <= LEAD_BYTE;
                        tx_valid  <= 1'b1;
                        tx_cnt    <= 4'h0;
                        frames_ok <= 16'(frames_ok + 16'h1);
                        state     <= ST_REPLY;
                    end else begin
                        frames_dropped <= 16'(frames_dropped + 16'h1); // [RULE3] [RULE16]
                        state          <= ST_COLLECT;
                    end
                end
                ST_REPLY: begin
                    // Host bytes arriving mid-reply are dropped
                    if (tx_fire) begin
                        if (tx_last) begin
                            tx_valid <= 1'b0; // [RULE1]
                            state    <= ST_COLLECT;
                        end else begin
                            tx_cnt  <= 4'(tx_cnt + 4'h1);
                            tx_data <= tx_buf[3'(tx_cnt + 4'h1)];
                        end
                    end
                end
                default: begin
                    state <= ST_COLLECT;
                end
            endcase
        end
    end

    // Settings and run strobes, applied only for accepted frames
    wire exec_ok = (state == ST_EXEC) && match && sum_ok; // [RULE9]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            motion_cfg.current_ma <= CUR_RESET;
            motion_cfg.home_speed <= HSPD_RESET;
            motion_cfg.speed_mode <= 1'b0;
            motion_cfg.direction  <= 1'b0;
            run_cmd               <= '0;
        end else begin
            run_cmd.start    <= exec_ok && do_step; // [RULE4]
            run_cmd.test_run <= exec_ok && do_test; // [RULE22]
            if (exec_ok && do_step) begin
                run_cmd.steps <= f_arg;
            end
            if (exec_ok && set_cur) begin
                motion_cfg.current_ma <= f_arg; // [RULE17]
            end
            if (exec_ok && set_hspd) begin
                motion_cfg.home_speed <= f_arg; // [RULE18]
            end
            if (exec_ok && set_mode) begin
                motion_cfg.speed_mode <= f_arg[0]; // [RULE19]
            end
            if (exec_ok && set_dir) begin
                motion_cfg.direction <= f_arg[0]; // [RULE20]
            end
        end
    end

    // AHB-Lite slave, zero wait states
    // Sub-word transfers are treated as unmapped
    wire       ahb_sel  = hsel && htrans[1] && hready;
    wire [7:0] rd_off   = haddr[7:0];
    wire       word_xfer = (hsize == 3'h2);
    wire       rd_known = (haddr[31:8] == 24'h0) && (rd_off[1:0] == 2'b00) &&
                          word_xfer;
    wire       addr_write = ahb_wr && (ahb_addr == REG_ADDR);
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0;
        if (rd_known) begin
            case (rd_off)
                REG_ADDR:    rd_mux = {24'h0, dev_addr};
                REG_STATUS:  rd_mux = {24'h0, 2'b00, state, stat_sync};
                REG_COUNT:   rd_mux = {frames_dropped, frames_ok};
                REG_CURRENT: rd_mux = motion_cfg.current_ma;
                REG_HSPD:    rd_mux = motion_cfg.home_speed;
                default:     rd_mux = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ahb_wr    <= 1'b0;
            ahb_addr  <= 8'h0;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            ahb_wr    <= ahb_sel && hwrite && rd_known;
            ahb_addr  <= rd_off;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (ahb_sel && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Device address, writable by software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dev_addr <= FACTORY_ADDR; // [RULE10]
        end else if (addr_write) begin
            dev_addr <= hwdata[7:0];
        end
    end
endmodule

// [design/frame_pkg.sv]
// Constants and types for the motor command frame parser
// How it works
// RULE1: Command and reply frames are exactly eight bytes, back to back.
// RULE2: Host starts each command with 0xa5, then address, code, data, checksum.
// RULE3: Wrong address or checksum gets no reply at all.
// RULE4: Step-run command is refused while the controller is busy.
// RULE5: Read instructions return the requested value in the data bytes.
// RULE6: Set instructions return the previous value; zero reads some settings.
// RULE7: A write the operating state forbids returns error 6.
// RULE8: Unknown code, or moving up on the home sensor, returns error 7.
// RULE9: An error reply means the setting stays unchanged.
// RULE10: Addresses 0x1 to 0x32 are valid; factory address is 0xff.
// RULE11: Reply byte two is always 0x7a.
// RULE12: Reply byte three carries the device's own address.
// RULE13: Data of argument-free instructions is ignored.
// RULE14: Data is signed 32-bit, least significant byte first.
// RULE15: Last byte is the low eight bits of the first seven bytes' sum.
// RULE16: A frame with a bad checksum is dropped without action.
// RULE17: Code 0x65 sets peak current, 400 to 3000 mA.
// RULE18: Code 0x39 sets homing speed, 1 to 256000 steps per second.
// RULE19: Code 0x4e enables speed mode on 1, disables on 0.
// RULE20: Code 0x64 selects direction, 0 backward, 1 forward.
// RULE21: Code 0x6a returns status word one, flags in bits 3 to 0.
// RULE22: Code 0x5a starts a test run of the stored user program.
// RULE23: A stalled partial frame is dropped after an idle timeout.
// RULE24: Reply only after a whole checked frame, never while host sends.
package frame_pkg;
    localparam logic [3:0]  FRAME_LEN     = 4'h8;
    localparam logic [7:0]  LEAD_BYTE     = 8'ha5;
    localparam logic [7:0]  REPLY_MARK    = 8'h7a;
    localparam logic [7:0]  FACTORY_ADDR  = 8'hff;
    localparam logic [7:0]  ADDR_MIN      = 8'h01;
    localparam logic [7:0]  ADDR_MAX      = 8'h32;
    localparam logic [7:0]  OP_CURRENT    = 8'h65;
    localparam logic [7:0]  OP_HOME_SPEED = 8'h39;
    localparam logic [7:0]  OP_SPEED_MODE = 8'h4e;
    localparam logic [7:0]  OP_DIRECTION  = 8'h64;
    localparam logic [7:0]  OP_STATUS1    = 8'h6a;
    localparam logic [7:0]  OP_TEST_RUN   = 8'h5a;
    localparam logic [7:0]  OP_STEP       = 8'h73;
    localparam logic [31:0] ERR_STATE     = 32'h0000_0006;
    localparam logic [31:0] ERR_UNKNOWN   = 32'h0000_0007;
    localparam logic [31:0] CUR_MIN       = 32'h0000_0190;
    localparam logic [31:0] CUR_MAX       = 32'h0000_0bb8;
    localparam logic [31:0] HSPD_MIN      = 32'h0000_0001;
    localparam logic [31:0] HSPD_MAX      = 32'h0003_e800;
    localparam logic [31:0] CUR_RESET     = 32'h0000_03e8;
    localparam logic [31:0] HSPD_RESET    = 32'h0000_03e8;
    localparam int          STAT_BUSY     = 0;
    localparam int          STAT_HOME     = 3;
    localparam int          CLK_KHZ       = 10000;
    localparam int          RX_TIMEOUT_MS = 10;
    localparam int          RX_TIMEOUT_CYC = RX_TIMEOUT_MS * CLK_KHZ;
    localparam logic [7:0]  REG_ADDR      = 8'h00;
    localparam logic [7:0]  REG_STATUS    = 8'h04;
    localparam logic [7:0]  REG_COUNT     = 8'h08;
    localparam logic [7:0]  REG_CURRENT   = 8'h0c;
    localparam logic [7:0]  REG_HSPD      = 8'h10;

    typedef struct packed {
        logic [31:0] current_ma;
        logic [31:0] home_speed;
        logic        speed_mode;
        logic        direction;
    } motion_cfg_t;

    typedef struct packed {
        logic        start;
        logic        test_run;
        logic [31:0] steps;
    } run_cmd_t;
endpackage

// [test/frame_parser_properties.sv]
// Concurrent checks on the reply link and the settings of the frame parser
`timescale 1ns/1ps
module frame_parser_properties (
    input wire logic                   hclk,
    input wire logic                   hresetn,
    input wire logic                   rx_valid,
    input wire logic                   tx_valid,
    input wire logic [7:0]             tx_data,
    input wire logic                   tx_ready,
    input wire frame_pkg::motion_cfg_t motion_cfg,
    input wire frame_pkg::run_cmd_t    run_cmd
);
    import frame_pkg::*;
    logic [2:0] tx_idx;
    logic [7:0] tx_sum;
    wire        take  = tx_valid && tx_ready;
    wire        pulse = run_cmd.start || run_cmd.test_run;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Byte position and running sum of the reply
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_idx <= 3'h0;
            tx_sum <= 8'h00;
        end else if (take) begin
            tx_idx <= tx_idx + 3'h1;
            tx_sum <= (tx_idx == 3'h7) ? 8'h00 : tx_sum + tx_data;
        end
    end
    sequence s_stall;
        tx_valid && !tx_ready;
    endsequence
    sequence s_pulse_once;
        $rose(tx_valid) ##1 !pulse;
    endsequence
    AST_TX_HOLD: assert property (s_stall |=> tx_valid && $stable(tx_data))
        else $error("reply byte changed before it was taken");
    AST_TX_CONT: assert property (take && tx_idx != 3'h7 |=> tx_valid)
        else $error("reply stopped before eight bytes");
    AST_TX_END: assert property (take && tx_idx == 3'h7 |=> !tx_valid)
        else $error("reply ran past eight bytes");
    AST_LEAD: assert property (tx_valid && tx_idx == 3'h0 |-> tx_data == LEAD_BYTE)
        else $error("reply lead byte wrong");
    AST_MARK: assert property (tx_valid && tx_idx == 3'h1 |-> tx_data == REPLY_MARK)
        else $error("reply marker byte wrong");
    AST_SUM: assert property (tx_valid && tx_idx == 3'h7 |-> tx_data == tx_sum)
        else $error("reply checksum wrong");
    AST_AFTER_RX: assert property ($rose(tx_valid) |->
        ($past(rx_valid, 2) || $past(rx_valid, 3)) && tx_idx == 3'h0)
        else $error("reply started without a finished frame");
    AST_CUR: assert property (motion_cfg.current_ma inside {[CUR_MIN:CUR_MAX]})
        else $error("peak current out of range");
    AST_HSPD: assert property (motion_cfg.home_speed inside {[HSPD_MIN:HSPD_MAX]})
        else $error("homing speed out of range");
    AST_CFG: assert property (!$stable(motion_cfg) |-> $rose(tx_valid))
        else $error("settings changed outside a reply");
    AST_PULSE: assert property (pulse |-> s_pulse_once)
        else $error("run pulse not one cycle at reply start");
endmodule
bind motor_command_frame_parser frame_parser_properties i_frame_parser_properties (
    .hclk(hclk), .hresetn(hresetn), .rx_valid(rx_valid), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .motion_cfg(motion_cfg), .run_cmd(run_cmd));

// [test/host_link_model.sv]
// Host model: sends command frames and takes reply bytes
`timescale 1ns/1ps
module host_link_model (
    input  wire logic  hclk,
    input  wire logic  slow,
    output logic       rx_valid,
    output logic [7:0] rx_data,
    output logic       tx_ready
);
    import frame_pkg::*;
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b1;
    end
    // Random reply stalls when slow
    always @(posedge hclk) tx_ready <= slow ? 1'($urandom) : 1'b1;
    task automatic send_cmd(input logic [7:0] addr, input logic [7:0] op,
                            input logic [31:0] data, input logic [7:0] sum_err, input int n);
        logic [63:0] f;
        f = {8'h00, data, op, addr, LEAD_BYTE};
        for (int i = 0; i < 7; i++)
            f[63:56] += f[8*i+:8];
        f[63:56] ^= sum_err;
        for (int i = 0; i < n; i++) begin
            rx_valid <= 1'b1;
            rx_data  <= f[8*i+:8];
            @(posedge hclk);
            if (slow) begin
                rx_valid <= 1'b0;
                rx_data  <= ~f[8*i+:8];
                @(posedge hclk);
            end
        end
        rx_valid <= 1'b0;
        rx_data  <= ~f[8*n-8+:8];
    endtask
endmodule

// [test/testbench.sv]
// Self-checking testbench for the motor command frame parser
`timescale 1ns/1ps
module testbench;
    import frame_pkg::*;
    localparam int TMO = 50;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat, v, prev;
    logic [1:0]  htrans = 2'h0;
    logic        hready, hresp, rx_valid, tx_valid, tx_ready;
    logic [7:0]  rx_data, tx_data, dev = 8'hff;
    logic [3:0]  status_pins = 4'h0;
    motion_cfg_t motion_cfg;
    run_cmd_t    run_cmd;
    logic [63:0] q[$], got;
    int          nb = 0, n_mismatch = 0, n_checks = 0, n_start = 0, n_test = 0;

    always #50 hclk = ~hclk;
    motor_command_frame_parser #(.RX_TIMEOUT(TMO)) i_motor_command_frame_parser (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .status_pins(status_pins), .motion_cfg(motion_cfg), .run_cmd(run_cmd));
    host_link_model i_host (.hclk(hclk), .slow(slow), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_ready(tx_ready));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR at %0t got %h expected %h", $time, g, e);
        end
    endtask
    function automatic logic [63:0] rep(input logic [7:0] a, input logic [31:0] d);
        logic [63:0] f;
        f = {8'h00, d, a, REPLY_MARK, LEAD_BYTE};
        for (int i = 0; i < 7; i++)
            f[63:56] += f[8*i+:8];
        return f;
    endfunction
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(64'({hresp, rdat & m}), 64'(e));
    endtask
    // Bad bit 0 spoils the checksum; any bad bit means no reply is due
    task automatic cmd(input logic [7:0] a, input logic [7:0] op, input logic [31:0] d,
                       input logic [31:0] e, input logic [1:0] bad);
        if (bad == 2'h0)
            q.push_back(rep(dev, e));
        i_host.send_cmd(a, op, d, {7'h0, bad[0]}, 8);
        for (int i = 0; i < 400 && q.size() != 0; i++)
            @(posedge hclk);
        repeat (30) @(posedge hclk);
        chk(64'(q.size()), 64'h0);
    endtask
    task automatic pins(input logic [3:0] p);
        status_pins <= p;
        repeat (4) @(posedge hclk);
    endtask
    // Collects reply bytes and run pulses, compares each whole frame
    always @(posedge hclk) begin
        if (run_cmd.start === 1'b1) n_start++;
        if (run_cmd.test_run === 1'b1) n_test++;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got[8*nb+:8] = tx_data;
            nb = (nb + 1) % 8;
            if (nb == 0)
                chk(got, q.size() != 0 ? q.pop_front() : ~got);
        end
    end
    initial begin
        repeat (30000) @(posedge hclk);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        void'($urandom(93670));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(REG_ADDR, 32'hff, 32'(FACTORY_ADDR));
        rd(REG_CURRENT, '1, CUR_RESET);
        rd(8'h40, '1, 32'h0);
        cmd(8'hff, OP_STATUS1, 32'h0, 32'h0, 2'h0);
        cmd(8'h05, OP_STATUS1, 32'h0, 32'h0, 2'h2);
        ahb(1'b1, REG_ADDR, 32'h05);
        dev = 8'h05;
        slow <= 1'b1;
        cmd(dev, OP_CURRENT, 32'd500, CUR_RESET, 2'h0);
        cmd(dev, OP_CURRENT, 32'd3001, ERR_STATE, 2'h0);
        cmd(dev, OP_CURRENT, 32'd399, ERR_STATE, 2'h0);
        cmd(dev, OP_CURRENT, 32'd0, 32'd500, 2'h0);
        rd(REG_CURRENT, '1, 32'd500);
        cmd(dev, OP_CURRENT, 32'd1000, 32'h0, 2'h1);
        rd(REG_CURRENT, '1, 32'd500);
        cmd(dev, OP_HOME_SPEED, 32'd256000, HSPD_RESET, 2'h0);
        cmd(dev, OP_HOME_SPEED, 32'd256001, ERR_STATE, 2'h0);
        cmd(dev, OP_HOME_SPEED, 32'd0, 32'd256000, 2'h0);
        rd(REG_HSPD, '1, 32'd256000);
        cmd(dev, OP_SPEED_MODE, 32'd1, 32'd0, 2'h0);
        cmd(dev, OP_SPEED_MODE, 32'd2, ERR_STATE, 2'h0);
        chk(64'(motion_cfg.speed_mode), 64'h1);
        cmd(dev, OP_SPEED_MODE, 32'd0, 32'd1, 2'h0);
        cmd(dev, OP_DIRECTION, 32'd1, 32'd0, 2'h0);
        chk(64'({motion_cfg.speed_mode, motion_cfg.direction}), 64'h1);
        cmd(dev, 8'h41, 32'h0, ERR_UNKNOWN, 2'h0);
        for (int i = 0; i < 4; i++) begin
            pins(4'($urandom));
            cmd(dev, OP_STATUS1, $urandom, {28'h0, status_pins}, 2'h0);
        end
        pins(4'h8);
        cmd(dev, OP_STEP, 32'd287, ERR_UNKNOWN, 2'h0);
        pins(4'h1);
        rd(REG_STATUS, 32'h3f, 32'h01);
        cmd(dev, OP_STEP, 32'd287, ERR_STATE, 2'h0);
        cmd(dev, OP_TEST_RUN, 32'h0, ERR_STATE, 2'h0);
        pins(4'h0);
        cmd(dev, OP_STEP, 32'd287, 32'd287, 2'h0);
        chk(64'({n_start, run_cmd.steps}), {32'd1, 32'd287});
        cmd(dev, OP_TEST_RUN, 32'h0, 32'h0, 2'h0);
        chk(64'(n_test), 64'd1);
        prev = 32'd500;
        for (int i = 0; i < 4; i++) begin
            v = 32'd400 + ($urandom % 2601);
            cmd(dev, OP_CURRENT, v, prev, 2'h0);
            prev = v;
        end
        ahb(1'b1, REG_ADDR, 32'h32);
        dev = 8'h32;
        cmd(dev, OP_DIRECTION, 32'd1, 32'd1, 2'h0);
        ahb(1'b1, REG_ADDR, 32'h33);
        cmd(8'h33, OP_DIRECTION, 32'd1, 32'd1, 2'h2);
        rd(REG_COUNT, 32'hffff0000, 32'h0003_0000);
        ahb(1'b1, REG_ADDR, 32'h32);
        i_host.send_cmd(dev, OP_DIRECTION, 32'd0, 8'h00, 3);
        repeat (TMO + 10) @(posedge hclk);
        cmd(dev, OP_DIRECTION, 32'd0, 32'd1, 2'h0);
        rd(REG_COUNT, 32'hffff0000, 32'h0004_0000);
        report_and_stop();
    end
endmodule
